//--- rtl/valve_pkg.sv
// Shared constants, codes and carriers for the valve channel data interface.
// Assumes a 10 MHz pclk and three measurement slices on that same clock.
package valve_pkg;
  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int NUM_DEV = 20;
  localparam int NUM_SLICE = 3;
  localparam int ITEM_COUNT = 16;
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = (TICK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam logic signed [15:0] VAL_MAX = 16'sh7D00;
  localparam logic signed [15:0] VAL_MIN = 16'sh8300;
  localparam logic [15:0] END_TIME_MAX = 16'h7FFF;
  localparam logic [2:0] END_STATE_MAX = 3'h6;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_TEST = 12'h004;
  localparam logic [11:0] ADDR_RUN = 12'h008;
  localparam logic [11:0] ADDR_PASS = 12'h00C;
  localparam logic [3:0] BANK_CFG = 4'h1;
  localparam logic [3:0] BANK_STATE = 4'h2;
  localparam logic [3:0] BANK_VI = 4'h3;
  localparam logic [3:0] BANK_CD = 4'h4;
  localparam logic [3:0] BANK_REC = 4'h5;
  localparam int CFG_ITEM_LSB = 0;
  localparam int CFG_TIME_LSB = 8;
  localparam int CFG_STATE_LSB = 24;
  localparam int ST_FB_LSB = 4;
  localparam int ST_TEST_LSB = 8;
  localparam int ST_TIMER_LSB = 16;
  localparam int HI_LSB = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  // Output circuit state codes
  typedef enum logic [2:0] {
    OUT_UNUSED = 3'h0, OUT_NO_SUPPLY = 3'h1, OUT_OFF = 3'h2, OUT_OPEN = 3'h3,
    OUT_ON = 3'h4, OUT_SHORT = 3'h5, OUT_LEAK = 3'h6, OUT_CH_FAULT = 3'h7
  } out_state_type;
  // Feedback codes: 1 to 5 are user voltage bands
  localparam logic [2:0] FB_LOW_FAULT = 3'h0;
  localparam logic [2:0] FB_HIGH_FAULT = 3'h6;
  localparam logic [2:0] FB_CH_FAULT = 3'h7;

  typedef enum logic [1:0] {TEST_IDLE, TEST_RUN, TEST_PASS, TEST_FAIL} test_state_type;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    out_state_type out_state;
    logic [2:0] fb_state;
    logic signed [15:0] volt;
    logic signed [15:0] curr;
    logic [7:0] item;
    logic [15:0] data;
  } meas_type;
endpackage

//--- rtl/slice_voter.sv
// Votes the three slice measurements of one field device into one value set.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module slice_voter
  import valve_pkg::*;
(
  input wire meas_type [NUM_SLICE-1:0] slices,
  output meas_type voted
);
  // ----------------------------------------------------------------------
  // Voting functions
  // ----------------------------------------------------------------------
  // Middle of three signed words
  function automatic logic signed [15:0] med_s(input logic signed [15:0] a, b, c);
    if ((a >= b) == (a <= c)) return a;
    if ((b >= a) == (b <= c)) return b;
    return c;
  endfunction

  // Middle of three unsigned words
  function automatic logic [15:0] med_u(input logic [15:0] a, b, c);
    if ((a >= b) == (a <= c)) return a;
    if ((b >= a) == (b <= c)) return b;
    return c;
  endfunction

  // Two of three agree; with no agreement the first slice stands
  function automatic logic [2:0] maj3(input logic [2:0] a, b, c);
    return (b == c) ? b : a;
  endfunction

  // Saturate to the reported integer span
  function automatic logic signed [15:0] clamp(input logic signed [17:0] v);
    if (v > 18'(VAL_MAX)) return VAL_MAX;
    if (v < 18'(VAL_MIN)) return VAL_MIN;
    return v[15:0];
  endfunction

  logic signed [17:0] curr_sum;
  logic [15:0] item_med;

  // Current is a sum, so it needs two guard bits before clamping
  assign curr_sum = 18'(slices[0].curr) + 18'(slices[1].curr) + 18'(slices[2].curr);
  assign item_med = med_u({8'h00, slices[0].item}, {8'h00, slices[1].item},
                          {8'h00, slices[2].item});

  // Field by field voting
  assign voted.out_state = out_state_type'(maj3(slices[0].out_state, slices[1].out_state,
                                                slices[2].out_state));
  assign voted.fb_state = maj3(slices[0].fb_state, slices[1].fb_state,
                               slices[2].fb_state);
  assign voted.volt = clamp(18'(med_s(slices[0].volt, slices[1].volt,
                                      slices[2].volt)));
  assign voted.curr = clamp(curr_sum);
  assign voted.item = item_med[7:0];
  assign voted.data = med_u(slices[0].data, slices[1].data, slices[2].data);
endmodule // slice_voter

//--- rtl/valve_channel_data_interface.sv
// Per-device command, valve test and voted report logic with an APB slave.
// Assumes slice data and scan_strobe are on pclk; the host writes once per scan.
`timescale 1ns/10ps
module valve_channel_data_interface
  import valve_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int ITEM_LIMIT = ITEM_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_strobe,
  input wire meas_type [NUM_DEV-1:0][NUM_SLICE-1:0] slice_in,
  output logic [NUM_DEV-1:0] field_out,
  output logic [NUM_DEV-1:0][7:0] req_item_out
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [NUM_DEV-1:0] cmd_q;
  logic [NUM_DEV-1:0] test_q;
  logic [NUM_DEV-1:0] test_prev_q;
  logic [NUM_DEV-1:0] field_out_q;
  logic [NUM_DEV-1:0] rise;
  logic [NUM_DEV-1:0] fall;
  logic [NUM_DEV-1:0] run_bits;
  logic [NUM_DEV-1:0] pass_bits;
  logic [NUM_DEV-1:0][7:0] req_item_q;
  logic [14:0] set_time_q [NUM_DEV];
  logic [2:0] set_state_q [NUM_DEV];
  logic [14:0] cap_time_q [NUM_DEV];
  logic [2:0] cap_state_q [NUM_DEV];
  logic [15:0] timer_q [NUM_DEV];
  logic [15:0] fb_volt_q [NUM_DEV];
  logic [15:0] cmd_time_q [NUM_DEV];
  test_state_type test_state_q [NUM_DEV];
  meas_type voted_w [NUM_DEV];
  meas_type voted_q [NUM_DEV];
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic pready_q;
  logic pslverr_q;
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_q;
  logic tick;
  logic access;
  logic wr_commit;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Device slot of a banked address; slots 20 to 31 are holes
  function automatic logic [4:0] dev_of(input logic [11:0] a);
    return a[6:2];
  endfunction

  // True when the address hits a defined register
  function automatic logic reg_ok(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_CMD || a == ADDR_TEST || a == ADDR_RUN || a == ADDR_PASS) begin
      hit = 1'b1;
    end else if (a[11:8] >= BANK_CFG && a[11:8] <= BANK_REC && a[7] == 1'b0 &&
                 a[1:0] == 2'b00 && int'(dev_of(a)) < NUM_DEV) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // One wait state: ready is registered so read data can come from a flop
  assign access = psel && penable && !pready_q;
  assign wr_commit = psel && penable && pwrite && pready_q && reg_ok(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RESET_WORD;
    end else if (ce) begin
      pready_q <= access;
      pslverr_q <= access && !reg_ok(paddr);
      if (access && !pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Read multiplexer over all banks
  always_comb begin
    logic [4:0] d;
    d = dev_of(paddr);
    rd_data = RESET_WORD;
    if (!reg_ok(paddr)) begin
      rd_data = RESET_WORD;
    end else if (paddr == ADDR_CMD) begin
      rd_data = 32'(cmd_q);
    end else if (paddr == ADDR_TEST) begin
      rd_data = 32'(test_q);
    end else if (paddr == ADDR_RUN) begin
      rd_data = 32'(run_bits);
    end else if (paddr == ADDR_PASS) begin
      rd_data = 32'(pass_bits);
    end else begin
      unique case (paddr[11:8])
        BANK_CFG: begin
          rd_data[CFG_ITEM_LSB +: 8] = req_item_q[d];
          rd_data[CFG_TIME_LSB +: 15] = set_time_q[d];
          rd_data[CFG_STATE_LSB +: 3] = set_state_q[d];
        end
        BANK_STATE: begin
          rd_data[2:0] = voted_q[d].out_state;
          rd_data[ST_FB_LSB +: 3] = voted_q[d].fb_state;
          rd_data[ST_TEST_LSB +: 2] = test_state_q[d];
          rd_data[ST_TIMER_LSB +: 16] = timer_q[d];
        end
        BANK_VI: begin
          rd_data[15:0] = voted_q[d].volt;
          rd_data[HI_LSB +: 8] = voted_q[d].item;
        end
        BANK_CD: begin
          rd_data[15:0] = voted_q[d].curr;
          rd_data[HI_LSB +: 16] = voted_q[d].data;
        end
        default: begin
          rd_data[15:0] = fb_volt_q[d];
          rd_data[HI_LSB +: 16] = cmd_time_q[d];
        end
      endcase
    end
  end

  // Command and test line words; bit d of each pairs up as device d
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
      test_q <= '0;
    end else if (ce && wr_commit) begin
      if (paddr == ADDR_CMD) begin
        cmd_q <= pwdata[NUM_DEV-1:0];
      end
      if (paddr == ADDR_TEST) begin
        test_q <= pwdata[NUM_DEV-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Scan edge detection and millisecond tick
  // ----------------------------------------------------------------------
  // Edges are judged once per scan so a mid-scan rewrite does not double-fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_prev_q <= '0;
    end else if (ce && scan_strobe) begin
      test_prev_q <= test_q;
    end
  end

  assign rise = {NUM_DEV{scan_strobe}} & test_q & ~test_prev_q;
  assign fall = {NUM_DEV{scan_strobe}} & ~test_q & test_prev_q;

  // Free-running tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (ce) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end
  assign tick = (int'(tick_cnt_q) == TICK_CYC - 1);

  // ----------------------------------------------------------------------
  // Per-device logic
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NUM_DEV; g++) begin : gen_dev
    slice_voter u_voter (
      .slices(slice_in[g]),
      .voted(voted_w[g])
    );

    assign run_bits[g] = (test_state_q[g] == TEST_RUN);
    assign pass_bits[g] = (test_state_q[g] == TEST_PASS);

    // Configuration word; invalid values are forced to zero on the way in
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        req_item_q[g] <= '0;
        set_time_q[g] <= '0;
        set_state_q[g] <= '0;
      end else if (ce && wr_commit && paddr[11:8] == BANK_CFG && int'(dev_of(paddr)) == g) begin
        req_item_q[g] <= (int'(pwdata[CFG_ITEM_LSB +: 8]) < ITEM_LIMIT) ?
                         pwdata[CFG_ITEM_LSB +: 8] : 8'h00;
        set_time_q[g] <= (pwdata[CFG_TIME_LSB +: 16] > END_TIME_MAX) ?
                         15'h0000 : pwdata[CFG_TIME_LSB +: 15];
        set_state_q[g] <= (pwdata[CFG_STATE_LSB +: 3] > END_STATE_MAX) ?
                          3'h0 : pwdata[CFG_STATE_LSB +: 3];
      end
    end

    // Valve test sequencer; abort outranks every other event
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        test_state_q[g] <= TEST_IDLE;
        timer_q[g] <= '0;
        cap_time_q[g] <= '0;
        cap_state_q[g] <= '0;
      end else if (ce) begin
        if (fall[g]) begin
          test_state_q[g] <= TEST_IDLE;
          timer_q[g] <= '0;
          cap_time_q[g] <= '0;
          cap_state_q[g] <= '0;
        end else if (rise[g]) begin
          cap_time_q[g] <= set_time_q[g];
          cap_state_q[g] <= set_state_q[g];
          timer_q[g] <= '0;
          // A zero end time or end state inhibits the
          test_state_q[g] <= (set_time_q[g] != '0 && set_state_q[g] != '0) ?
                             TEST_RUN : TEST_IDLE;
        end else if (test_state_q[g] == TEST_RUN && tick) begin
          timer_q[g] <= timer_q[g] + 16'h0001;
          if (voted_q[g].fb_state == cap_state_q[g]) begin
            test_state_q[g] <= TEST_PASS;
          end else if (timer_q[g] + 16'h0001 >= {1'b0, cap_time_q[g]}) begin
            test_state_q[g] <= TEST_FAIL;
          end
        end
      end
    end

    // Recorded results survive an abort; only a new pass overwrites them
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fb_volt_q[g] <= '0;
        cmd_time_q[g] <= '0;
      end else if (ce && !fall[g] && !rise[g] && test_state_q[g] == TEST_RUN && tick &&
                   voted_q[g].fb_state == cap_state_q[g]) begin
        fb_volt_q[g] <= voted_q[g].volt;
        cmd_time_q[g] <= timer_q[g] + 16'h0001;
      end
    end

    // Field output follows the command; a running test strokes it off
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        field_out_q[g] <= 1'b0;
      end else if (ce) begin
        field_out_q[g] <= cmd_q[g] && (test_state_q[g] != TEST_RUN);
      end
    end

    // Voted report, refreshed every cycle that ce is high
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        voted_q[g] <= '0;
      end else if (ce) begin
        voted_q[g] <= voted_w[g];
      end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    a_out_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && test_state_q[g] != TEST_RUN) |=> field_out_q[g] == $past(cmd_q[g]))
      else $error("field output does not follow command");
    a_test_start: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rise[g] && !fall[g] && set_time_q[g] != '0 && set_state_q[g] != '0)
      |=> test_state_q[g] == TEST_RUN ##1 (!ce || field_out_q[g] == 1'b0))
      else $error("test did not start on rise");
    a_abort_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && fall[g]) |=> test_state_q[g] == TEST_IDLE && timer_q[g] == '0 &&
      cap_time_q[g] == '0 && cap_state_q[g] == '0)
      else $error("abort left test data");
    a_keep_record: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && fall[g]) |=> $stable(fb_volt_q[g]) && $stable(cmd_time_q[g]))
      else $error("abort cleared recorded values");
    a_end_capture: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rise[g]) |=> cap_time_q[g] == $past(set_time_q[g]) &&
      cap_state_q[g] == $past(set_state_q[g]))
      else $error("end values not captured");
    a_item_clamp: assert property (@(posedge pclk) disable iff (!presetn)
      int'(req_item_q[g]) < ITEM_LIMIT)
      else $error("requested item off list");
    a_vote_sample: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> voted_q[g] == $past(voted_w[g]))
      else $error("voted report not refreshed");
    a_value_span: assert property (@(posedge pclk) disable iff (!presetn)
      voted_q[g].volt >= VAL_MIN && voted_q[g].volt <= VAL_MAX &&
      voted_q[g].curr >= VAL_MIN && voted_q[g].curr <= VAL_MAX)
      else $error("reported value out of span");
    a_edge_track: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && scan_strobe) |=> test_prev_q[g] == $past(test_q[g]))
      else $error("previous test line not kept");
  end

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pready_q) |=> !pready_q)
    else $error("ready held over two cycles");

  c_test_pass: cover property (@(posedge pclk) disable iff (!presetn)
    test_state_q[0] == TEST_RUN ##[1:1000] test_state_q[0] == TEST_PASS);
  c_test_fail: cover property (@(posedge pclk) disable iff (!presetn)
    test_state_q[0] == TEST_RUN ##[1:1000] test_state_q[0] == TEST_FAIL);
  c_test_abort: cover property (@(posedge pclk) disable iff (!presetn)
    test_state_q[0] == TEST_RUN ##1 fall[0]);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr_q && pready_q);

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign field_out = field_out_q;
  assign req_item_out = req_item_q;
endmodule // valve_channel_data_interface

//--- test/valve_slice_model.sv
// Model of the three measurement slices that sit behind the data interface.
// Assumes the bench sets the per-slice readings; all devices share them.
`timescale 1ns/10ps
module valve_slice_model
  import valve_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_DEV-1:0] field_out,
  input wire logic [NUM_DEV-1:0][7:0] req_item_out,
  input wire logic [NUM_SLICE-1:0][15:0] volt_s,
  input wire logic [NUM_SLICE-1:0][15:0] curr_s,
  input wire logic [NUM_SLICE-1:0][2:0] fb_s,
  output logic scan_strobe,
  output meas_type [NUM_DEV-1:0][NUM_SLICE-1:0] slice_in
);
  logic [3:0] scan_cnt_q;

  // ----------------------------------------------------------------------
  // Scan pacing
  // ----------------------------------------------------------------------
  // Host scan every 16 cycles, far shorter than a real scan to keep runs brief
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_q <= 4'h0;
    end else begin
      scan_cnt_q <= scan_cnt_q + 4'h1;
    end
  end
  assign scan_strobe = (scan_cnt_q == 4'hF);

  // ----------------------------------------------------------------------
  // Slice readings
  // ----------------------------------------------------------------------
  // Slice 0 always disagrees on the output state so the vote is exercised
  always_comb begin
    for (int d = 0; d < NUM_DEV; d++) begin
      for (int k = 0; k < NUM_SLICE; k++) begin
        slice_in[d][k].out_state = (k == 0) ? OUT_CH_FAULT : (field_out[d] ? OUT_ON : OUT_OFF);
        slice_in[d][k].fb_state = fb_s[k];
        slice_in[d][k].volt = volt_s[k];
        slice_in[d][k].curr = curr_s[k];
        slice_in[d][k].item = req_item_out[d];
        slice_in[d][k].data = {8'h00, req_item_out[d]} + 16'(k);
      end
    end
  end
endmodule // valve_slice_model

//--- test/valve_channel_data_interface_tb_top.sv
// Self-checking bench: APB host tasks, slice model, command and test scenarios.
// Assumes a short millisecond tick (TICK_CYC = 10); ce drops low once to check the freeze.
`timescale 1ns/10ps
module valve_channel_data_interface_tb_top
  import valve_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, scan_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_DEV-1:0] field_out;
  logic [NUM_DEV-1:0][7:0] req_item_out;
  logic [NUM_SLICE-1:0][15:0] volt_s, curr_s;
  logic [NUM_SLICE-1:0][2:0] fb_s;
  meas_type [NUM_DEV-1:0][NUM_SLICE-1:0] slice_in;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  valve_channel_data_interface #(.TICK_CYC(10), .ITEM_LIMIT(16)) i_valve_channel_data_interface (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scan_strobe(scan_strobe), .slice_in(slice_in),
    .field_out(field_out), .req_item_out(req_item_out));
  valve_slice_model i_valve_slice_model (
    .pclk(pclk), .presetn(presetn), .field_out(field_out), .req_item_out(req_item_out),
    .volt_s(volt_s), .curr_s(curr_s), .fb_s(fb_s), .scan_strobe(scan_strobe),
    .slice_in(slice_in));

  // ----------------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // A hang is cut off well beyond the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // ----------------------------------------------------------------------
  // APB host
  // ----------------------------------------------------------------------
  // Request held steady until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) n_errors++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] r;
    logic err;
    apb(1'b0, a, 32'h0000_0000, r, err);
    chk(nm, e, r & m);
    chk("pslverr", 1'b0, err);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic err;
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    volt_s = {16'h0032, 16'hFED4, 16'h0064};  // Slices 2..0: 50, -300, 100
    curr_s = {16'hEC78, 16'h4E20, 16'h4E20};  // Sum 35000 saturates
    fb_s = {3'h2, 3'h2, 3'h3};
    idle(2);
    presetn <= 1'b1;
    chk("field_out", 32'h0, 32'(field_out));
    rdc("cmd", ADDR_CMD, 32'hFFFF_FFFF, 32'h0);
    wr(ADDR_CMD, 32'h0008_0001);  // Devices 0 and 19 energised
    idle(3);
    chk("field_out", 32'h0008_0001, 32'(field_out));
    rdc("cmd", ADDR_CMD, 32'hFFFF_FFFF, 32'h0008_0001);
    wr(ADDR_RUN, 32'h000F_FFFF);
    rdc("run", ADDR_RUN, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("hole", 32'h1, {31'h0, err});
    // Item 5, end time 200 ms, end state 5; item 20 is off the list
    wr(12'h100, 32'h0500_C805);
    wr(12'h104, 32'h0500_C814);
    idle(40);
    rdc("vi0", 12'h300, 32'hFFFF_FFFF, 32'h0005_0032);
    rdc("cd0", 12'h400, 32'hFFFF_FFFF, 32'h0006_7D00);
    chk("req_item0", 32'h5, 32'(req_item_out[0]));
    chk("req_item1", 32'h0, 32'(req_item_out[1]));
    rdc("vi1", 12'h304, 32'hFFFF_FFFF, 32'h0000_0032);
    rdc("state0", 12'h200, 32'hFFFF_FFFF, 32'h0000_0024);
    volt_s <= {16'h7FFF, 16'h7FFF, 16'h0000};
    idle(3);
    rdc("vclamp", 12'h300, 32'h0000_FFFF, 32'h0000_7D00);
    // Test started with feedback away from the end state runs to its time limit
    wr(ADDR_TEST, 32'h0000_0001);
    idle(20);  // Let a scan take the rise before the end values change
    wr(12'h100, 32'h0100_0105);  // Ignored until the next start
    idle(40);
    rdc("test_run", 12'h200, 32'h0000_0300, 32'h0000_0100);
    rdc("run", ADDR_RUN, 32'hFFFF_FFFF, 32'h1);
    chk("field_out_run", 32'h0008_0000, 32'(field_out));
    idle(1500);
    rdc("still_run", 12'h200, 32'h0000_0300, 32'h0000_0100);
    // Clock enable low freezes the test timer, so the limit moves out
    ce <= 1'b0;
    idle(600);
    ce <= 1'b1;
    idle(300);
    rdc("frozen_run", 12'h200, 32'h0000_0300, 32'h0000_0100);
    idle(800);
    rdc("test_fail", 12'h200, 32'h0000_0300, 32'h0000_0300);
    wr(ADDR_TEST, 32'h0000_0000);
    idle(40);
    rdc("abort", 12'h200, 32'hFFFF_FFFF, 32'h0000_0024);
    // Feedback reaching the end state passes the test, then an abort keeps the record
    wr(12'h100, 32'h0500_C805);
    fb_s <= {3'h5, 3'h5, 3'h3};
    wr(ADDR_TEST, 32'h0000_0001);
    idle(40);
    rdc("test_pass", 12'h200, 32'h0000_0370, 32'h0000_0250);
    rdc("pass", ADDR_PASS, 32'hFFFF_FFFF, 32'h1);
    // Pass on the first tick: 1 ms, voltage clamped to 32000
    rdc("rec_pass", 12'h500, 32'hFFFF_FFFF, 32'h0001_7D00);
    wr(ADDR_TEST, 32'h0000_0000);
    idle(40);
    rdc("rec_kept", 12'h500, 32'hFFFF_FFFF, 32'h0001_7D00);
    rdc("idle", 12'h200, 32'hFFFF_0300, 32'h0000_0000);
    final_report();
  end
endmodule // valve_channel_data_interface_tb_top
